// File: src/epch_cmd_handler.sv
`timescale 1ns/1ns
`include "epch_consts.svh"
module epch_cmd_handler #(
  parameter logic [7:0]  MODEL_ID = 8'hA5,       // arbitrary value
  parameter logic [31:0] SERIAL   = 32'h0000_0001, // arbitrary value
  parameter logic [15:0] FW_VER   = 16'h0100     // arbitrary value
) (
  input  wire logic        clk_sys_i,      // 20 MHz system clock
  input  wire logic        sys_rst_i,      // sync reset, active high
  input  wire logic        rx_valid_i,     // received byte strobe
  input  wire logic [7:0]  rx_byte_i,      // received byte
  input  wire logic        rx_last_i,      // byte closes the frame
  input  wire logic        rx_par_err_i,   // parity error on this byte
  input  wire logic        rx_csum_err_i,  // frame checksum mismatch
  input  wire logic [31:0] position_i,     // raw shaft position
  input  wire logic [7:0]  temp_c_i,       // temperature, degrees C
  input  wire logic        f_ang_ofs_i,    // stored angular offset bad
  input  wire logic        f_part_tbl_i,   // partition table corrupt
  input  wire logic        f_ana_lim_i,    // analog limits missing
  input  wire logic        f_i2c_i,        // internal two-wire bus failed
  input  wire logic        f_int_csum_i,   // internal checksum error
  input  wire logic        f_wdog_i,       // restarted by watchdog
  input  wire logic        f_ana_mon_i,    // analog amplitude violation
  input  wire logic        f_tx_cur_i,     // transmitter current critical
  input  wire logic        f_temp_i,       // temperature critical
  input  wire logic        f_speed_i,      // speed too high
  input  wire logic        f_st_pos_i,     // single-turn pos unreliable
  output logic             tx_valid_o,     // reply byte strobe
  output logic [7:0]       tx_byte_o,      // reply byte
  output logic             tx_last_o,      // last reply byte
  output logic             busy_o,         // frame being executed
  output logic [7:0]       status_o        // current status code
);

  localparam int FLD_NUM = `EPCH_FLD_NUM;
  localparam int AW      = 11;

  if (`EPCH_MEM_BYTES != FLD_NUM * 256) begin : g_chk
    $error("field partition does not match memory size");
  end

  epch_mem_if #(.AW(AW)) mem_bus ();

  epch_user_mem #(
    .DEPTH (`EPCH_MEM_BYTES),
    .AW    (AW)
  ) u_mem (
    .clk_sys_i (clk_sys_i),
    .port_i    (mem_bus.mem)
  );

  epch_pkg::epch_state_type state_ff;
  epch_pkg::epch_byte_type  rx_buf_ff [`EPCH_RX_MAX];
  epch_pkg::epch_byte_type  rep_ff    [`EPCH_TX_MAX];
  logic [2:0]   rx_cnt_ff;      // bytes held, saturates
  logic         rx_ovf_ff;      // more bytes than buffer
  logic         par_ff;
  logic         csum_ff;
  logic [2:0]   rep_len_ff;
  logic [2:0]   rep_idx_ff;
  logic [7:0]   code_ff;
  logic [15:0]  cnt_ff;
  logic [31:0]  pos_ofs_ff;
  logic [10:0]  free_ff;
  logic [7:0]   fld_size_ff [FLD_NUM];
  logic [FLD_NUM-1:0] fld_used_ff;
  logic [FLD_NUM-1:0] fld_wp_ff;
  logic [FLD_NUM-1:0] fld_fix_ff;
  logic [7:0]   last_err_ff;
  logic [7:0]   fault_ff;
  logic [AW-1:0] mem_addr_ff;
  logic [7:0]   mem_wdata_ff;
  logic         mem_we_ff;

  // expected argument count per command, 7 marks unknown
  function automatic logic [2:0] arg_count(input logic [7:0] cmd);
    case (cmd)
      `EPCH_CMD_RD_POS, `EPCH_CMD_RD_CNT, `EPCH_CMD_INC_CNT,
      `EPCH_CMD_FREE_MEM, `EPCH_CMD_RD_STAT, `EPCH_CMD_RD_TYPE,
      `EPCH_CMD_RD_SERNO:                    arg_count = 3'd0;
      `EPCH_CMD_RD_ANA, `EPCH_CMD_CLR_CNT,
      `EPCH_CMD_FLD_STAT:                    arg_count = 3'd1;
      `EPCH_CMD_RD_DATA, `EPCH_CMD_CHG_CODE: arg_count = 3'd2;
      `EPCH_CMD_ST_DATA:                     arg_count = 3'd3;
      `EPCH_CMD_MK_FLD:                      arg_count = 3'd4;
      `EPCH_CMD_SET_POS:                     arg_count = 3'd5;
      default:                               arg_count = 3'd7;
    endcase
  endfunction : arg_count

  // field check shared by read, store and status commands
  function automatic logic [7:0] fld_check(input logic [7:0] fld,
                                           input logic [7:0] addr,
                                           input logic       use_addr);
    if (fld >= 8'(FLD_NUM)) begin
      fld_check = `EPCH_ST_ARG;
    end else if (!fld_used_ff[fld[2:0]]) begin
      fld_check = `EPCH_ST_NO_FLD;
    end else if (use_addr && addr >= fld_size_ff[fld[2:0]]) begin
      fld_check = `EPCH_ST_ADDR;
    end else begin
      fld_check = `EPCH_ST_OK;
    end
  endfunction : fld_check

  logic [7:0] cmd;
  logic [2:0] nargs;
  logic [7:0] fchk;
  logic [11:0] room;
  assign cmd   = rx_buf_ff[0];
  assign nargs = rx_cnt_ff - 3'd1;
  assign fchk  = fld_check(rx_buf_ff[1], rx_buf_ff[2],
                           cmd != `EPCH_CMD_FLD_STAT);
  assign room  = {1'b0, free_ff} + {4'h0, fld_size_ff[rx_buf_ff[1][2:0]]};

  // device fault status, highest priority first
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      fault_ff <= `EPCH_ST_OK;
    end else if (f_ang_ofs_i) begin
      fault_ff <= `EPCH_ST_ANG_OFS;
    end else if (f_part_tbl_i) begin
      fault_ff <= `EPCH_ST_PART_TBL;
    end else if (f_ana_lim_i) begin
      fault_ff <= `EPCH_ST_ANA_LIM;
    end else if (f_i2c_i) begin
      fault_ff <= `EPCH_ST_I2C;
    end else if (f_int_csum_i) begin
      fault_ff <= `EPCH_ST_INT_CSUM;
    end else if (f_wdog_i) begin
      fault_ff <= `EPCH_ST_WDOG;
    end else if (f_ana_mon_i) begin
      fault_ff <= `EPCH_ST_ANA_MON;
    end else if (f_tx_cur_i) begin
      fault_ff <= `EPCH_ST_TX_CUR;
    end else if (f_temp_i) begin
      fault_ff <= `EPCH_ST_TEMP;
    end else if (f_speed_i) begin
      fault_ff <= `EPCH_ST_SPEED;
    end else if (f_st_pos_i) begin
      fault_ff <= `EPCH_ST_ST_POS;
    end else begin
      fault_ff <= `EPCH_ST_OK;
    end
  end

  // visible status: device fault, else last command result
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      status_o <= `EPCH_ST_OK;
    end else begin
      status_o <= (fault_ff != `EPCH_ST_OK) ? fault_ff : last_err_ff;
    end
  end

  assign mem_bus.addr  = mem_addr_ff;
  assign mem_bus.wdata = mem_wdata_ff;
  assign mem_bus.we    = mem_we_ff;

  // frame collection, execution and reply sequencing
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state_ff     <= epch_pkg::ST_COLLECT;
      rx_cnt_ff    <= 3'd0;
      rx_ovf_ff    <= 1'b0;
      par_ff       <= 1'b0;
      csum_ff      <= 1'b0;
      rep_len_ff   <= 3'd0;
      rep_idx_ff   <= 3'd0;
      code_ff      <= `EPCH_CODE_RST;
      cnt_ff       <= `EPCH_CNT_RST;
      pos_ofs_ff   <= 32'h0000_0000;
      free_ff      <= `EPCH_FREE_RST;
      fld_used_ff  <= '0;
      fld_wp_ff    <= '0;
      fld_fix_ff   <= '0;
      last_err_ff  <= `EPCH_ST_OK;
      mem_addr_ff  <= '0;
      mem_wdata_ff <= 8'h00;
      mem_we_ff    <= 1'b0;
      busy_o       <= 1'b0;
      tx_valid_o   <= 1'b0;
      tx_byte_o    <= 8'h00;
      tx_last_o    <= 1'b0;
      for (int i = 0; i < FLD_NUM; i++) begin
        fld_size_ff[i] <= 8'h00;
      end
      for (int i = 0; i < `EPCH_RX_MAX; i++) begin
        rx_buf_ff[i] <= 8'h00;
        rep_ff[i]    <= 8'h00;
      end
    end else begin
      mem_we_ff  <= 1'b0;
      tx_valid_o <= 1'b0;
      tx_last_o  <= 1'b0;
      rep_len_ff <= 3'd1;
      rep_ff[0]  <= `EPCH_ST_OK;
      case (state_ff)
        // gather bytes until the frame closes
        epch_pkg::ST_COLLECT: begin
          if (rx_valid_i) begin
            if (rx_cnt_ff < 3'(`EPCH_RX_MAX)) begin
              rx_buf_ff[rx_cnt_ff] <= rx_byte_i;
              rx_cnt_ff <= rx_cnt_ff + 3'd1;
            end else begin
              rx_ovf_ff <= 1'b1;
            end
            par_ff  <= par_ff | rx_par_err_i;
            csum_ff <= rx_last_i & rx_csum_err_i;
            if (rx_last_i) begin
              state_ff <= epch_pkg::ST_EXEC;
              busy_o   <= 1'b1;
            end
          end
        end
        // decode and carry out the command
        epch_pkg::ST_EXEC: begin
          state_ff <= epch_pkg::ST_SEND;
          if (par_ff) begin
            rep_ff[0] <= `EPCH_ST_PARITY;
          end else if (csum_ff) begin
            rep_ff[0] <= `EPCH_ST_CSUM;
          end else if (arg_count(cmd) == 3'd7) begin
            rep_ff[0] <= `EPCH_ST_UNK_CMD;
          end else if (rx_ovf_ff || nargs != arg_count(cmd)) begin
            rep_ff[0] <= `EPCH_ST_LEN;
          end else begin
            case (cmd)
              `EPCH_CMD_RD_POS: begin
                {rep_ff[0], rep_ff[1], rep_ff[2], rep_ff[3]} <=
                  position_i + pos_ofs_ff;
                rep_len_ff <= 3'd4;
              end
              `EPCH_CMD_SET_POS: begin
                if (rx_buf_ff[5] != code_ff) begin
                  rep_ff[0] <= `EPCH_ST_CODE;
                end else begin
                  pos_ofs_ff <= {rx_buf_ff[1], rx_buf_ff[2], rx_buf_ff[3],
                                 rx_buf_ff[4]} - position_i;
                end
              end
              `EPCH_CMD_RD_ANA: begin
                if (rx_buf_ff[1] != `EPCH_CH_TEMP) begin
                  rep_ff[0] <= `EPCH_ST_ARG;
                end else begin
                  rep_ff[0] <= temp_c_i;
                end
              end
              `EPCH_CMD_RD_CNT: begin
                {rep_ff[0], rep_ff[1]} <= cnt_ff;
                rep_len_ff <= 3'd2;
              end
              `EPCH_CMD_INC_CNT: begin
                if (cnt_ff == `EPCH_CNT_MAX) begin
                  rep_ff[0] <= `EPCH_ST_CNT_OVF;
                end else begin
                  cnt_ff <= cnt_ff + 16'h0001;
                end
              end
              `EPCH_CMD_CLR_CNT: begin
                if (rx_buf_ff[1] != code_ff) begin
                  rep_ff[0] <= `EPCH_ST_CODE;
                end else begin
                  cnt_ff <= `EPCH_CNT_RST;
                end
              end
              `EPCH_CMD_RD_DATA: begin
                mem_addr_ff <= {rx_buf_ff[1][2:0], rx_buf_ff[2]};
                if (fchk != `EPCH_ST_OK) begin
                  rep_ff[0] <= fchk;
                end else begin
                  state_ff <= epch_pkg::ST_MEMRD;
                end
              end
              `EPCH_CMD_ST_DATA: begin
                if (fchk != `EPCH_ST_OK) begin
                  rep_ff[0] <= fchk;
                end else if (fld_wp_ff[rx_buf_ff[1][2:0]]) begin
                  rep_ff[0] <= `EPCH_ST_WR_PROT;
                end else begin
                  mem_addr_ff  <= {rx_buf_ff[1][2:0], rx_buf_ff[2]};
                  mem_wdata_ff <= rx_buf_ff[3];
                  mem_we_ff    <= 1'b1;
                end
              end
              `EPCH_CMD_FLD_STAT: begin
                if (fchk == `EPCH_ST_ARG) begin
                  rep_ff[0] <= fchk;
                end else begin
                  rep_ff[0] <= {5'h00, fld_used_ff[rx_buf_ff[1][2:0]],
                                fld_fix_ff[rx_buf_ff[1][2:0]],
                                fld_wp_ff[rx_buf_ff[1][2:0]]};
                  rep_ff[1]  <= fld_size_ff[rx_buf_ff[1][2:0]];
                  rep_len_ff <= 3'd2;
                end
              end
              `EPCH_CMD_MK_FLD: begin
                if (rx_buf_ff[4] != code_ff) begin
                  rep_ff[0] <= `EPCH_ST_CODE;
                end else if (rx_buf_ff[1] >= 8'(FLD_NUM)) begin
                  rep_ff[0] <= `EPCH_ST_ARG;
                end else if (fld_used_ff[rx_buf_ff[1][2:0]] &&
                             fld_fix_ff[rx_buf_ff[1][2:0]]) begin
                  rep_ff[0] <= `EPCH_ST_FIXED;
                end else if (rx_buf_ff[2] == 8'h00 ||
                             {4'h0, rx_buf_ff[2]} > room) begin
                  rep_ff[0] <= `EPCH_ST_ARG;
                end else begin
                  fld_used_ff[rx_buf_ff[1][2:0]] <= 1'b1;
                  fld_size_ff[rx_buf_ff[1][2:0]] <= rx_buf_ff[2];
                  fld_wp_ff[rx_buf_ff[1][2:0]]  <=
                    rx_buf_ff[3][`EPCH_FLG_WP];
                  fld_fix_ff[rx_buf_ff[1][2:0]] <=
                    rx_buf_ff[3][`EPCH_FLG_FIX];
                  free_ff <= 11'(room - {4'h0, rx_buf_ff[2]});
                end
              end
              `EPCH_CMD_FREE_MEM: begin
                {rep_ff[0], rep_ff[1]} <= {5'h00, free_ff};
                rep_len_ff <= 3'd2;
              end
              `EPCH_CMD_CHG_CODE: begin
                if (rx_buf_ff[1] != code_ff) begin
                  rep_ff[0] <= `EPCH_ST_CODE;
                end else begin
                  code_ff <= rx_buf_ff[2];
                end
              end
              `EPCH_CMD_RD_STAT: rep_ff[0] <= status_o;
              `EPCH_CMD_RD_TYPE: rep_ff[0] <= MODEL_ID;
              `EPCH_CMD_RD_SERNO: begin
                {rep_ff[0], rep_ff[1], rep_ff[2], rep_ff[3], rep_ff[4],
                 rep_ff[5]} <= {SERIAL, FW_VER};
                rep_len_ff <= 3'd6;
              end
              default: rep_ff[0] <= `EPCH_ST_UNK_CMD;
            endcase
          end
        end
        // registered memory read lands one cycle later
        epch_pkg::ST_MEMRD: begin
          state_ff <= epch_pkg::ST_SEND;
          if (rep_idx_ff == 3'd1) begin
            rep_ff[0]  <= mem_bus.rdata;
            rep_idx_ff <= 3'd0;
          end else begin
            state_ff   <= epch_pkg::ST_MEMRD;
            rep_idx_ff <= 3'd1;
          end
        end
        // stream the reply, one byte a cycle
        epch_pkg::ST_SEND: begin
          rep_len_ff <= rep_len_ff;
          rep_ff[0]  <= rep_ff[0];
          tx_valid_o <= 1'b1;
          tx_byte_o  <= rep_ff[rep_idx_ff];
          if (rep_idx_ff == 3'd0) begin
            last_err_ff <= (rep_len_ff == 3'd1 && rep_ff[0] >= 8'h02 &&
                            cmd != `EPCH_CMD_RD_ANA &&
                            cmd != `EPCH_CMD_RD_TYPE &&
                            cmd != `EPCH_CMD_RD_DATA &&
                            cmd != `EPCH_CMD_RD_STAT) ?
                           rep_ff[0] : `EPCH_ST_OK;
          end
          if (rep_idx_ff == rep_len_ff - 3'd1) begin
            tx_last_o  <= 1'b1;
            rep_idx_ff <= 3'd0;
            rx_cnt_ff  <= 3'd0;
            rx_ovf_ff  <= 1'b0;
            par_ff     <= 1'b0;
            csum_ff    <= 1'b0;
            busy_o     <= 1'b0;
            state_ff   <= epch_pkg::ST_COLLECT;
          end else begin
            rep_idx_ff <= rep_idx_ff + 3'd1;
          end
        end
        default: state_ff <= epch_pkg::ST_COLLECT;
      endcase
    end
  end

endmodule : epch_cmd_handler

// File: src/epch_consts.svh
`ifndef EPCH_CONSTS_SVH
`define EPCH_CONSTS_SVH

// command bytes
`define EPCH_CMD_RD_POS    8'h42
`define EPCH_CMD_SET_POS   8'h43
`define EPCH_CMD_RD_ANA    8'h44
`define EPCH_CMD_RD_CNT    8'h46
`define EPCH_CMD_INC_CNT   8'h47
`define EPCH_CMD_CLR_CNT   8'h49
`define EPCH_CMD_RD_DATA   8'h4A
`define EPCH_CMD_ST_DATA   8'h4B
`define EPCH_CMD_FLD_STAT  8'h4C
`define EPCH_CMD_MK_FLD    8'h4D
`define EPCH_CMD_FREE_MEM  8'h4E
`define EPCH_CMD_CHG_CODE  8'h4F
`define EPCH_CMD_RD_STAT   8'h50
`define EPCH_CMD_RD_TYPE   8'h52
`define EPCH_CMD_RD_SERNO  8'h56

// analog channel carrying the temperature
`define EPCH_CH_TEMP       8'h48

// status codes
`define EPCH_ST_OK         8'h00
`define EPCH_ST_ANG_OFS    8'h02
`define EPCH_ST_PART_TBL   8'h03
`define EPCH_ST_ANA_LIM    8'h04
`define EPCH_ST_I2C        8'h05
`define EPCH_ST_INT_CSUM   8'h06
`define EPCH_ST_WDOG       8'h07
`define EPCH_ST_CNT_OVF    8'h08
`define EPCH_ST_PARITY     8'h09
`define EPCH_ST_CSUM       8'h0A
`define EPCH_ST_UNK_CMD    8'h0B
`define EPCH_ST_LEN        8'h0C
`define EPCH_ST_ARG        8'h0D
`define EPCH_ST_WR_PROT    8'h0E
`define EPCH_ST_CODE       8'h0F
`define EPCH_ST_FIXED      8'h10
`define EPCH_ST_ADDR       8'h11
`define EPCH_ST_NO_FLD     8'h12
`define EPCH_ST_ANA_MON    8'h1C
`define EPCH_ST_TX_CUR     8'h1D
`define EPCH_ST_TEMP       8'h1E
`define EPCH_ST_SPEED      8'h1F
`define EPCH_ST_ST_POS     8'h20

// reset values and counter limit
`define EPCH_CODE_RST      8'h55
`define EPCH_CNT_RST       16'h0000
`define EPCH_CNT_MAX       16'hFFFF

// user memory layout
`define EPCH_MEM_BYTES     1792
`define EPCH_FLD_NUM       7
`define EPCH_FREE_RST      11'h700

// field flag bit positions in the create/status flag byte
`define EPCH_FLG_WP        0
`define EPCH_FLG_FIX       1
`define EPCH_FLG_USED      2

// frame and reply buffer sizes
`define EPCH_RX_MAX        6
`define EPCH_TX_MAX        6

`endif

// File: src/epch_pkg.sv
package epch_pkg;

  typedef enum logic [1:0] {
    ST_COLLECT,
    ST_EXEC,
    ST_MEMRD,
    ST_SEND
  } epch_state_type;

  typedef logic [7:0] epch_byte_type;

endpackage : epch_pkg

// File: src/epch_mem_if.sv
`timescale 1ns/1ns
// user memory port between command handler and storage
interface epch_mem_if #(
  parameter int AW = 11
);
  logic [AW-1:0] addr;
  logic [7:0]    wdata;
  logic          we;
  logic [7:0]    rdata;

  modport ctl (output addr, output wdata, output we, input rdata);
  modport mem (input addr, input wdata, input we, output rdata);
endinterface : epch_mem_if

// File: src/epch_user_mem.sv
`timescale 1ns/1ns
// single port user data store, registered read
module epch_user_mem #(
  parameter int DEPTH = 1792,
  parameter int AW    = 11
) (
  input  wire logic clk_sys_i,  // system clock
  epch_mem_if.mem   port_i      // access port
);

  logic [7:0] mem_ff [DEPTH];

  // refuse a depth the address cannot reach
  if (DEPTH > (1 << AW)) begin : g_chk
    $error("memory depth exceeds address range");
  end

  // write and registered read
  always_ff @(posedge clk_sys_i) begin
    if (port_i.we) begin
      mem_ff[port_i.addr] <= port_i.wdata;
    end
    port_i.rdata <= mem_ff[port_i.addr];
  end

endmodule : epch_user_mem

// File: bench/epch_cmd_handler_asserts.sv
`timescale 1ns/1ns
// reply timing and status checks at the handler ports
module epch_cmd_handler_asserts #(
  parameter logic [7:0] MODEL_ID = 8'hA5  // arbitrary value
) (
  input wire logic       clk_sys_i,      // clock
  input wire logic       sys_rst_i,      // reset
  input wire logic       rx_valid_i,     // rx strobe
  input wire logic [7:0] rx_byte_i,      // rx byte
  input wire logic       rx_last_i,      // rx end
  input wire logic       rx_par_err_i,   // parity
  input wire logic       rx_csum_err_i,  // checksum
  input wire logic       tx_valid_o,     // tx strobe
  input wire logic [7:0] tx_byte_o,      // tx byte
  input wire logic       tx_last_o,      // tx end
  input wire logic       busy_o          // busy
);
  logic first_ff;  // next taken byte opens a frame
  logic one;       // one-byte frame taken now
  logic ok;        // same, free of link errors
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  // follow frame starts
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i)
      first_ff <= 1'b1;
    else if (rx_valid_i && !busy_o)
      first_ff <= rx_last_i;
  end
  // frame qualifiers
  assign one = first_ff && rx_valid_i && rx_last_i && !busy_o;
  assign ok  = one && !rx_par_err_i && !rx_csum_err_i;
  a_reset_quiet: assert property (
    $fell(sys_rst_i) |-> !tx_valid_o && !busy_o) else $error("not idle");
  a_busy_on_take: assert property (
    rx_valid_i && rx_last_i && !busy_o |=> busy_o) else $error("no busy");
  // busy falls with the last reply byte, so the next frame may follow
  a_busy_release: assert property (
    tx_last_o |-> (tx_valid_o && !busy_o) ##1 !busy_o)
    else $error("busy held");
  a_reply_in_busy: assert property (
    tx_valid_o && !tx_last_o |-> busy_o) else $error("reply outside busy");
  // first reply byte stands three edges after the last byte is taken
  a_type_reply: assert property (
    ok && rx_byte_i == 8'h52 |=> ##2 tx_valid_o && tx_last_o
    && tx_byte_o == MODEL_ID) else $error("bad type reply");
  a_parity_code: assert property (
    one && rx_par_err_i |=> ##2 tx_valid_o && tx_byte_o == 8'h09)
    else $error("bad parity status");
  a_csum_code: assert property (
    one && !rx_par_err_i && rx_csum_err_i |=> ##2 tx_valid_o
    && tx_byte_o == 8'h0A) else $error("bad checksum status");
  a_unknown_code: assert property (
    ok && rx_byte_i == 8'h60 |=> ##2 tx_valid_o && tx_byte_o == 8'h0B)
    else $error("bad unknown status");
endmodule : epch_cmd_handler_asserts

bind epch_cmd_handler epch_cmd_handler_asserts #(.MODEL_ID(MODEL_ID)) i_chk (
  .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .rx_valid_i(rx_valid_i),
  .rx_byte_i(rx_byte_i), .rx_last_i(rx_last_i), .busy_o(busy_o),
  .rx_par_err_i(rx_par_err_i), .rx_csum_err_i(rx_csum_err_i),
  .tx_valid_o(tx_valid_o), .tx_byte_o(tx_byte_o), .tx_last_o(tx_last_o));

// File: bench/epch_host_model.sv
`timescale 1ns/1ns
// drive side: sends a frame byte by byte, gathers the reply
module epch_host_model (
  input  wire logic       clk_sys_i,  // clock
  output logic            vld_o,      // byte strobe
  output logic [7:0]      byte_o,     // byte
  output logic            last_o,     // frame end
  output logic            par_o,      // parity mark
  output logic            csum_o,     // checksum mark
  input  wire logic       tx_vld_i,   // reply strobe
  input  wire logic       tx_last_i,  // reply end
  input  wire logic [7:0] tx_byte_i   // reply byte
);
  logic [7:0] rep[$];  // reply bytes
  // idle lines at time zero
  initial begin
    {vld_o, last_o, par_o, csum_o} = 4'h0;
    byte_o = 8'h00;
  end
  // whole frame as given, error marks as asked, then a bounded wait for the reply
  task automatic xfer(input logic [7:0] f[$], input logic pe,
                      input logic ce, output bit to);
    int n;
    rep.delete();
    foreach (f[i]) begin
      vld_o <= 1'b1;
      byte_o <= f[i];
      last_o <= i == f.size() - 1;
      par_o <= pe;
      csum_o <= ce && i == f.size() - 1;
      @(posedge clk_sys_i);
    end
    // released data line shows the inverse of the last byte
    {vld_o, last_o, par_o, csum_o} <= 4'h0;
    byte_o <= ~f[f.size() - 1];
    for (n = 0; n < 20; n++) begin
      @(negedge clk_sys_i);
      if (tx_vld_i)
        rep.push_back(tx_byte_i);
      if (tx_vld_i && tx_last_i)
        break;
    end
    to = n == 20;
    @(posedge clk_sys_i);
  endtask : xfer
endmodule : epch_host_model

// File: bench/epch_cmd_handler_tb_top.sv
`timescale 1ns/1ns
// host model sends frames, replies compared byte by byte
module epch_cmd_handler_tb_top;
  `define chk(a, b) begin total_checks++; if ((a) !== (b)) begin n_errors++; \
    $display("Error %0t got %h exp %h", $time, a, b); end end
  `define xf(f, e) xfr($bits(f) / 8, f, $bits(e) / 8, e)
  logic        clk_sys_i, sys_rst_i, vld, lst, par, csm, txv, txl, bsy;
  logic [7:0]  rxb, tmp, txb, sts;
  logic [31:0] pos;
  logic [10:0] flt;
  int          n_errors = 0;
  int          total_checks = 0;
  // 50 ns clock
  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  epch_cmd_handler #(.MODEL_ID(8'h3C), .SERIAL(32'h12345678), // arbitrary
    .FW_VER(16'h0203)) i_dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .rx_valid_i(vld), .rx_byte_i(rxb), .rx_last_i(lst), .rx_par_err_i(par),
    .rx_csum_err_i(csm), .position_i(pos), .temp_c_i(tmp),
    .f_ang_ofs_i(flt[0]), .f_part_tbl_i(flt[1]), .f_ana_lim_i(flt[2]),
    .f_i2c_i(flt[3]), .f_int_csum_i(flt[4]), .f_wdog_i(flt[5]),
    .f_ana_mon_i(flt[6]), .f_tx_cur_i(flt[7]), .f_temp_i(flt[8]),
    .f_speed_i(flt[9]), .f_st_pos_i(flt[10]), .tx_valid_o(txv),
    .tx_byte_o(txb), .tx_last_o(txl), .busy_o(bsy), .status_o(sts));
  epch_host_model i_host (.clk_sys_i(clk_sys_i), .vld_o(vld), .byte_o(rxb),
    .last_o(lst), .par_o(par), .csum_o(csm), .tx_vld_i(txv),
    .tx_last_i(txl), .tx_byte_i(txb));
  // counts, verdict, end of run
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  // one frame out, expected reply bytes compared
  task automatic xfr(input int nf, input logic [47:0] f, input int ne,
                     input logic [47:0] e, input logic pe = 1'b0,
                     input logic ce = 1'b0);
    logic [7:0] q[$];
    bit         to;
    for (int i = nf - 1; i >= 0; i--)
      q.push_back(f[8*i+:8]);
    i_host.xfer(q, pe, ce, to);
    if (to) begin
      n_errors++;
      finish_test();
    end
    `chk(i_host.rep.size(), ne)
    for (int i = 0; i < ne; i++)
      `chk(i_host.rep[i], e[8*(ne-1-i)+:8])
  endtask : xfr
  // identity, reads and link errors
  task automatic t_basic();
    `chk(sts, 8'h00)
    `xf(8'h52, 8'h3C);
    `xf(8'h56, 48'h123456780203);
    `xf(16'h4448, 8'h19);
    `xf(16'h4447, 8'h0D);
    `xf(8'h4E, 16'h0700);
    xfr(1, 48'h60, 1, 48'h09, 1'b1);
    xfr(1, 48'h60, 1, 48'h0A, 1'b0, 1'b1);
    `xf(8'h60, 8'h0B);
    `xf(16'h4600, 8'h0C);
    $display("t_basic done");
  endtask : t_basic
  // counter, access code, code restored by reset
  task automatic t_count();
    `xf(8'h46, 16'h0000);
    `xf(16'h4900, 8'h0F);
    `xf(8'h47, 8'h00);
    `xf(8'h46, 16'h0001);
    `xf(24'h4F5566, 8'h00);
    `xf(16'h4955, 8'h0F);
    `xf(16'h4966, 8'h00);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_sys_i);
    `xf(16'h4955, 8'h00);
    `xf(8'h46, 16'h0000);
    $display("t_count done");
  endtask : t_count
  // data fields and position offset
  task automatic t_field();
    `xf(24'h4A0000, 8'h12);
    `xf(40'h4D00010155, 8'h00);
    `xf(32'h4B0000AA, 8'h0E);
    `xf(16'h4C00, 16'h0501);
    `xf(24'h4A0001, 8'h11);
    `xf(40'h4D01020255, 8'h00);
    `xf(40'h4D01030255, 8'h10);
    `xf(8'h50, 8'h10);
    `xf(8'h4E, 16'h06FD);
    `xf(48'h430000123455, 8'h00);
    pos <= 32'h00000101;
    `xf(8'h42, 32'h00001235);
    // store and read back through the user memory
    `xf(40'h4D02040055, 8'h00);
    `xf(32'h4B020177, 8'h00);
    `xf(24'h4A0201, 8'h77);
    $display("t_field done");
  endtask : t_field
  // each fault with all lower ones raised
  task automatic t_faults();
    logic [7:0] c[11] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h1C,
                          8'h1D, 8'h1E, 8'h1F, 8'h20};
    for (int i = 0; i < 11; i++) begin
      flt <= 11'h7FF << i;
      repeat (2) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      `chk(sts, c[i])
      @(posedge clk_sys_i);
    end
    flt <= 11'h000;
    $display("t_faults done");
  endtask : t_faults
  // main sequence
  initial begin
    sys_rst_i = 1'b1;
    pos = 32'h00000100;
    tmp = 8'h19;
    flt = 11'h000;
    repeat (8) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_sys_i);
    t_basic();
    t_count();
    t_field();
    t_faults();
    finish_test();
  end
endmodule : epch_cmd_handler_tb_top
